// [src/tcc_map.svh]
`ifndef TCC_MAP_SVH
`define TCC_MAP_SVH
// Notes on behaviour
// - Without auto start, power up idle and wait for a begin command.
// - With auto start, begin converting at power-up in the stored mode.
// - Single-conversion-mode bit picks continuous or one conversion per command.
// - Continuous mode repeats conversions until halt, then goes idle.
// - Idle after halt, a begin command resumes continuous conversions at any time.
// - Single mode: one conversion per begin command, then idle until next.
// - Auto start in single mode does one conversion after power-up, then idle.
// - Result is signed, resolution 9 to 12 bits, in degrees Celsius.
// - Temperature register: 16 bits, read only, volatile, resets to c400.
// - Upper trip point: 16 bits, read/write, nonvolatile, factory 0f00.
// - Lower trip point: 16 bits, read/write, nonvolatile, factory 0a00.
// - Config upper six bits volatile; polarity and mode bits nonvolatile.
// - Config powers up 100011 above the two stored low bits.
// - Nonvolatile write completes within 10 ms, typically 4 ms.
// - Resolution powers up at 12 bits, changed by two select bits.
// - Conversion time doubles with each extra resolution bit.

`define TCC_CLK_MHZ          50
`define TCC_CONV9_US         93750
`define TCC_NV_WRITE_TYP_MS  4
`define TCC_NV_WRITE_MAX_MS  10

`define TCC_TEMP_RESET       16'hc400
`define TCC_UPPER_RESET      16'h0f00
`define TCC_LOWER_RESET      16'h0a00
`define TCC_CFG_HI_RESET     6'h23
`define TCC_CFG_NV_RESET     2'h0

`define TCC_BUS_ADDR_HI      4'h9
`define TCC_CMD_BEGIN        8'h01
`define TCC_CMD_HALT         8'h02
`define TCC_CMD_TEMP         8'h10
`define TCC_CMD_UPPER        8'h11
`define TCC_CMD_LOWER        8'h12
`define TCC_CMD_CONFIG       8'h13
`define TCC_READ_FILL        8'hff
`endif

// [src/tcc_pkg.sv]
package tcc_pkg;
  typedef struct packed {
    logic       done;
    logic       high_flag;
    logic       low_flag;
    logic       nv_busy;
    logic [1:0] resolution;
    logic       output_polarity;
    logic       single_conversion_mode;
  } tcc_cfg_t;

  typedef struct packed {
    logic       valid;
    logic [1:0] index;
    logic [7:0] data;
  } tcc_rx_t;

  typedef enum logic [0:0] {TCC_IDLE, TCC_CONV} tcc_conv_st_t;

  typedef enum logic [2:0] {
    TCC_B_IDLE,
    TCC_B_ADDR,
    TCC_B_ACK,
    TCC_B_WRITE,
    TCC_B_READ,
    TCC_B_MACK
  } tcc_bus_st_t;
endpackage : tcc_pkg

// [src/tcc_i2c_slave.sv]
`timescale 1ns/1ps
module tcc_i2c_slave (
  input  wire logic        clk,       // System clock
  input  wire logic        rst_b,     // Async reset, active low
  input  wire logic        scl_pin,   // Raw serial clock
  input  wire logic        sda_pin,   // Raw serial data level
  input  wire logic [6:0]  own_addr,  // Bus address
  input  wire logic [7:0]  tx_byte,   // Byte to send at tx_index
  output tcc_pkg::tcc_rx_t rx,        // Received data byte event
  output logic      [1:0]  tx_index,  // Byte position in transfer
  output logic             sda_oe     // Pull data line low
);
  logic [1:0]          scl_sync;
  logic [1:0]          sda_sync;
  logic                scl_q;
  logic                sda_q;
  logic [7:0]          shift;
  logic [3:0]          bit_cnt;
  logic                rw;
  tcc_pkg::tcc_bus_st_t st;

  function automatic logic [1:0] sat_inc(input logic [1:0] v);
    sat_inc = (v == 2'h3) ? v : v + 2'h1;
  endfunction : sat_inc

  wire scl_rise   = scl_sync[1] & ~scl_q;
  wire scl_fall   = ~scl_sync[1] & scl_q;
  wire start_cond = scl_sync[1] & scl_q & sda_q & ~sda_sync[1];
  wire stop_cond  = scl_sync[1] & scl_q & ~sda_q & sda_sync[1];
  wire addr_hit   = shift[7:1] == own_addr;
  wire byte_in    = scl_fall && bit_cnt == 4'h8;

  always_ff @(posedge clk or negedge rst_b)
    if (!rst_b)
    begin
      scl_sync <= 2'h3;
      sda_sync <= 2'h3;
      scl_q    <= 1'b1;
      sda_q    <= 1'b1;
    end
    else
    begin
      scl_sync <= {scl_sync[0], scl_pin};
      sda_sync <= {sda_sync[0], sda_pin};
      scl_q    <= scl_sync[1];
      sda_q    <= sda_sync[1];
    end

  always_ff @(posedge clk or negedge rst_b)
    if (!rst_b)
    begin
      st       <= tcc_pkg::TCC_B_IDLE;
      shift    <= 8'h00;
      bit_cnt  <= 4'h0;
      rw       <= 1'b0;
      tx_index <= 2'h0;
      sda_oe   <= 1'b0;
      rx       <= '0;
    end
    else
    begin
      rx.valid <= 1'b0;
      if (stop_cond)
      begin
        st     <= tcc_pkg::TCC_B_IDLE;
        sda_oe <= 1'b0;
      end
      else if (start_cond)
      begin
        st       <= tcc_pkg::TCC_B_ADDR;
        bit_cnt  <= 4'h0;
        tx_index <= 2'h0;
        sda_oe   <= 1'b0;
      end
      else
        case (st)
          tcc_pkg::TCC_B_ADDR, tcc_pkg::TCC_B_WRITE:
            if (scl_rise)
            begin
              shift   <= {shift[6:0], sda_sync[1]};
              bit_cnt <= bit_cnt + 4'h1;
            end
            else if (byte_in && st == tcc_pkg::TCC_B_ADDR && !addr_hit)
              st <= tcc_pkg::TCC_B_IDLE;
            else if (byte_in)
            begin
              sda_oe <= 1'b1;
              st     <= tcc_pkg::TCC_B_ACK;
              if (st == tcc_pkg::TCC_B_ADDR)
                rw <= shift[0];
              else
              begin
                rx.valid <= 1'b1;
                rx.data  <= shift;
                rx.index <= tx_index;
                tx_index <= sat_inc(tx_index);
              end
            end
          tcc_pkg::TCC_B_ACK:
            if (scl_fall)
            begin
              bit_cnt <= 4'h0;
              if (rw)
              begin
                shift    <= tx_byte;
                sda_oe   <= ~tx_byte[7];
                tx_index <= sat_inc(tx_index);
                st       <= tcc_pkg::TCC_B_READ;
              end
              else
              begin
                sda_oe <= 1'b0;
                st     <= tcc_pkg::TCC_B_WRITE;
              end
            end
          tcc_pkg::TCC_B_READ:
            if (scl_fall && bit_cnt == 4'h7)
            begin
              sda_oe <= 1'b0;
              st     <= tcc_pkg::TCC_B_MACK;
            end
            else if (scl_fall)
            begin
              shift   <= {shift[6:0], 1'b0};
              sda_oe  <= ~shift[6];
              bit_cnt <= bit_cnt + 4'h1;
            end
          tcc_pkg::TCC_B_MACK:
            if (scl_rise && sda_sync[1])
              st <= tcc_pkg::TCC_B_IDLE;
            else if (scl_fall)
            begin
              bit_cnt  <= 4'h0;
              shift    <= tx_byte;
              sda_oe   <= ~tx_byte[7];
              tx_index <= sat_inc(tx_index);
              st       <= tcc_pkg::TCC_B_READ;
            end
          default:
            st <= tcc_pkg::TCC_B_IDLE;
        endcase
    end
endmodule : tcc_i2c_slave

// [src/tcc_top.sv]
`timescale 1ns/1ps
`include "tcc_map.svh"
module tcc_top #(
  parameter logic        AUTO_START      = 1'b0,
  parameter logic [25:0] CONV9_CYCLES    = 26'(`TCC_CONV9_US * `TCC_CLK_MHZ),
  parameter logic [18:0] NV_WRITE_CYCLES = 19'(`TCC_NV_WRITE_TYP_MS * 1000 * `TCC_CLK_MHZ)
) (
  input  wire logic        CLK_SYS,        // 50 MHz system clock
  input  wire logic        RST_B,          // Power-up reset, active low
  input  wire logic        SCL,            // Serial clock pin
  input  wire logic        SDA_IN,         // Serial data pin level
  output logic             SDA_OUT,        // Serial data drive value
  output logic             SDA_OE,         // Serial data drive enable
  input  wire logic        BUS_ADDR_SEL0,  // Address select pin 0
  input  wire logic        BUS_ADDR_SEL1,  // Address select pin 1
  input  wire logic        BUS_ADDR_SEL2,  // Address select pin 2
  input  wire logic [11:0] TEMP_SAMPLE,    // Converter result, signed
  output logic             SENSOR_ACTIVE,  // Conversion in progress
  output logic             CONV_DONE,      // Conversion finished pulse
  output logic             NV_WRITE_BUSY   // Nonvolatile write running
);
  localparam logic [18:0] NV_MAX_CYCLES = 19'(`TCC_NV_WRITE_MAX_MS * 1000 * `TCC_CLK_MHZ);

  logic [2:0]            addr_sync1;
  logic [2:0]            addr_sync2;
  tcc_pkg::tcc_rx_t      rx;
  logic [1:0]            tx_index;
  logic [7:0]            tx_byte;
  logic                  sda_oe_i;
  logic [7:0]            cmd;
  logic [7:0]            hold_msb;
  logic [15:0]           temp_reg;
  logic [15:0]           upper_reg;
  logic [15:0]           lower_reg;
  tcc_pkg::tcc_cfg_t     cfg;
  tcc_pkg::tcc_conv_st_t st;
  logic [25:0]           conv_cnt;
  logic [25:0]           conv_limit;
  logic [1:0]            res_latch;
  logic                  conv_single;
  logic                  run;
  logic                  boot;
  logic [18:0]           nv_cnt;

  function automatic logic [15:0] res_mask(input logic [1:0] res);
    res_mask = 16'($signed(16'hff80) >>> res);
  endfunction : res_mask

  tcc_i2c_slave u_bus (
    .clk      (CLK_SYS),
    .rst_b    (RST_B),
    .scl_pin  (SCL),
    .sda_pin  (SDA_IN),
    .own_addr ({`TCC_BUS_ADDR_HI, addr_sync2}),
    .tx_byte  (tx_byte),
    .rx       (rx),
    .tx_index (tx_index),
    .sda_oe   (sda_oe_i)
  );

  wire cmd_byte   = rx.valid && rx.index == 2'h0;
  wire data1      = rx.valid && rx.index == 2'h1;
  wire data2      = rx.valid && rx.index == 2'h2;
  wire begin_cmd  = cmd_byte && rx.data == `TCC_CMD_BEGIN;
  wire halt_cmd   = cmd_byte && rx.data == `TCC_CMD_HALT;
  wire conv_done  = st == tcc_pkg::TCC_CONV && conv_cnt == conv_limit - 26'h1;
  wire start_conv = st == tcc_pkg::TCC_IDLE && (begin_cmd || (boot && AUTO_START));
  wire restart    = conv_done && !conv_single && run && !halt_cmd;
  wire nv_free    = !cfg.nv_busy;
  wire upper_wr   = data2 && cmd == `TCC_CMD_UPPER && nv_free;
  wire lower_wr   = data2 && cmd == `TCC_CMD_LOWER && nv_free;
  wire cfg_wr     = data1 && cmd == `TCC_CMD_CONFIG;
  wire nv_bits_wr = cfg_wr && nv_free
                    && rx.data[1:0] != {cfg.output_polarity, cfg.single_conversion_mode};
  wire nv_start   = upper_wr || lower_wr || nv_bits_wr;

  wire [15:0] next_temp = {TEMP_SAMPLE, 4'h0} & res_mask(res_latch);
  wire [15:0] read_word = (cmd == `TCC_CMD_TEMP)  ? temp_reg :
                          (cmd == `TCC_CMD_UPPER) ? upper_reg :
                          (cmd == `TCC_CMD_LOWER) ? lower_reg : 16'hffff;
  assign tx_byte = (cmd == `TCC_CMD_CONFIG) ? ((tx_index == 2'h0) ? cfg : `TCC_READ_FILL) :
                   (tx_index == 2'h0) ? read_word[15:8] :
                   (tx_index == 2'h1) ? read_word[7:0] : `TCC_READ_FILL;

  always_ff @(posedge CLK_SYS or negedge RST_B)
    if (!RST_B)
    begin
      addr_sync1 <= 3'h0;
      addr_sync2 <= 3'h0;
      SDA_OUT    <= 1'b0;
      SDA_OE     <= 1'b0;
    end
    else
    begin
      addr_sync1 <= {BUS_ADDR_SEL2, BUS_ADDR_SEL1, BUS_ADDR_SEL0};
      addr_sync2 <= addr_sync1;
      SDA_OUT    <= 1'b0;
      SDA_OE     <= sda_oe_i;
    end

  always_ff @(posedge CLK_SYS or negedge RST_B)
    if (!RST_B)
    begin
      cmd      <= 8'h00;
      hold_msb <= 8'h00;
    end
    else
    begin
      if (cmd_byte)
        cmd <= rx.data;
      if (data1)
        hold_msb <= rx.data;
    end

  // Conversion sequencer; mode and resolution are frozen for each conversion
  always_ff @(posedge CLK_SYS or negedge RST_B)
    if (!RST_B)
    begin
      st            <= tcc_pkg::TCC_IDLE;
      conv_cnt      <= 26'h0;
      conv_limit    <= CONV9_CYCLES;
      res_latch     <= 2'h3;
      conv_single   <= 1'b0;
      SENSOR_ACTIVE <= 1'b0;
      CONV_DONE     <= 1'b0;
    end
    else
    begin
      CONV_DONE <= conv_done;
      case (st)
        tcc_pkg::TCC_IDLE:
          if (start_conv)
          begin
            st            <= tcc_pkg::TCC_CONV;
            conv_cnt      <= 26'h0;
            conv_limit    <= CONV9_CYCLES << cfg.resolution;
            res_latch     <= cfg.resolution;
            conv_single   <= cfg.single_conversion_mode;
            SENSOR_ACTIVE <= 1'b1;
          end
        tcc_pkg::TCC_CONV:
          if (restart)
          begin
            conv_cnt      <= 26'h0;
            conv_limit    <= CONV9_CYCLES << cfg.resolution;
            res_latch     <= cfg.resolution;
            conv_single   <= cfg.single_conversion_mode;
          end
          else if (conv_done)
          begin
            st            <= tcc_pkg::TCC_IDLE;
            SENSOR_ACTIVE <= 1'b0;
          end
          else
            conv_cnt <= conv_cnt + 26'h1;
        default:
          st <= tcc_pkg::TCC_IDLE;
      endcase
    end

  always_ff @(posedge CLK_SYS or negedge RST_B)
    if (!RST_B)
    begin
      boot     <= 1'b1;
      run      <= 1'b0;
      temp_reg <= `TCC_TEMP_RESET;
    end
    else
    begin
      boot <= 1'b0;
      if (halt_cmd)
        run <= 1'b0;
      else if (start_conv)
        run <= 1'b1;
      if (conv_done)
        temp_reg <= next_temp;
    end

  // Trip points and configuration with nonvolatile write timing
  always_ff @(posedge CLK_SYS or negedge RST_B)
    if (!RST_B)
    begin
      upper_reg <= `TCC_UPPER_RESET;
      lower_reg <= `TCC_LOWER_RESET;
      cfg       <= {`TCC_CFG_HI_RESET, `TCC_CFG_NV_RESET};
      nv_cnt    <= 19'h0;
    end
    else
    begin
      if (upper_wr)
        upper_reg <= {hold_msb, rx.data};
      if (lower_wr)
        lower_reg <= {hold_msb, rx.data};
      if (start_conv)
        cfg.done <= 1'b0;
      else if (conv_done)
        cfg.done <= 1'b1;
      if (cfg_wr)
      begin
        cfg.high_flag  <= cfg.high_flag & rx.data[6];
        cfg.low_flag   <= cfg.low_flag & rx.data[5];
        cfg.resolution <= rx.data[3:2];
      end
      if (nv_bits_wr)
      begin
        cfg.output_polarity        <= rx.data[1];
        cfg.single_conversion_mode <= rx.data[0];
      end
      if (nv_start)
        nv_cnt <= NV_WRITE_CYCLES;
      else if (nv_cnt != 19'h0)
        nv_cnt <= nv_cnt - 19'h1;
      cfg.nv_busy <= nv_start || nv_cnt > 19'h1;
    end

  assign NV_WRITE_BUSY = cfg.nv_busy;

  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!RST_B);

  property p_idle_wait;
    !AUTO_START && st == tcc_pkg::TCC_IDLE && !begin_cmd |=> !SENSOR_ACTIVE;
  endproperty
  a_idle_wait: assert property (p_idle_wait) else $error("conversion without begin");
  property p_auto_go;
    AUTO_START && boot |=> SENSOR_ACTIVE && conv_cnt == 26'h0;
  endproperty
  a_auto_go: assert property (p_auto_go) else $error("no auto start");
  property p_mode_pick;
    start_conv |=> conv_single == $past(cfg.single_conversion_mode);
  endproperty
  a_mode_pick: assert property (p_mode_pick) else $error("mode not taken");
  property p_cont_next;
    restart |=> SENSOR_ACTIVE ##1 conv_cnt == 26'h1;
  endproperty
  a_cont_next: assert property (p_cont_next) else $error("continuous stopped");
  property p_halt_end;
    conv_done && !run |=> st == tcc_pkg::TCC_IDLE && !SENSOR_ACTIVE;
  endproperty
  a_halt_end: assert property (p_halt_end) else $error("halt ignored");
  property p_resume;
    begin_cmd && st == tcc_pkg::TCC_IDLE |=> SENSOR_ACTIVE && run;
  endproperty
  a_resume: assert property (p_resume) else $error("begin ignored in idle");
  property p_single_end;
    conv_done && conv_single |=> !SENSOR_ACTIVE && cfg.done && CONV_DONE;
  endproperty
  a_single_end: assert property (p_single_end) else $error("single did not stop");
  property p_auto_single;
    AUTO_START && boot && cfg.single_conversion_mode |=> conv_single;
  endproperty
  a_auto_single: assert property (p_auto_single) else $error("auto single wrong");
  property p_result;
    conv_done |=> temp_reg == ({$past(TEMP_SAMPLE), 4'h0} & res_mask($past(res_latch)));
  endproperty
  a_result: assert property (p_result) else $error("result wrong");
  property p_temp_hold;
    !conv_done |=> $stable(temp_reg);
  endproperty
  a_temp_hold: assert property (p_temp_hold) else $error("result changed early");
  property p_duration;
    start_conv || restart |=> conv_limit == (CONV9_CYCLES << $past(cfg.resolution));
  endproperty
  a_duration: assert property (p_duration) else $error("duration wrong");
  property p_ignore;
    begin_cmd && st == tcc_pkg::TCC_CONV && !conv_done |=> conv_cnt == $past(conv_cnt) + 26'h1;
  endproperty
  a_ignore: assert property (p_ignore) else $error("begin restarted conversion");
  property p_nv_bound;
    nv_cnt <= NV_WRITE_CYCLES && NV_WRITE_CYCLES <= NV_MAX_CYCLES
      && cfg.nv_busy == (nv_cnt != 19'h0);
  endproperty
  a_nv_bound: assert property (p_nv_bound) else $error("nv write too long");
  property p_nv_refuse;
    data2 && cmd == `TCC_CMD_UPPER && cfg.nv_busy |=> $stable(upper_reg);
  endproperty
  a_nv_refuse: assert property (p_nv_refuse) else $error("write during nv cycle");
  property p_nv_bits_keep;
    cfg_wr && cfg.nv_busy |=> $stable({cfg.output_polarity, cfg.single_conversion_mode});
  endproperty
  a_nv_bits_keep: assert property (p_nv_bits_keep) else $error("nv bits changed busy");
  property p_frozen;
    st == tcc_pkg::TCC_CONV && !conv_done |=> $stable(res_latch) && $stable(conv_single);
  endproperty
  a_frozen: assert property (p_frozen) else $error("setting changed mid conversion");
  property p_low_zero;
    temp_reg[3:0] == 4'h0;
  endproperty
  a_low_zero: assert property (p_low_zero) else $error("result low bits set");
endmodule : tcc_top

// [sim/tcc_host_model.sv]
`timescale 1ns/1ps
module tcc_host_model (
  input  wire logic clk,     // System clock
  input  wire logic dev_oe,  // Device pulls data low
  output logic      scl,     // Serial clock, idle high
  output logic      sda      // Data wire level
);
  logic host_oe = 1'b0;

  // Pull-up: a released wire reads high
  assign sda = !(host_oe | dev_oe);

  initial scl = 1'b1;

  task automatic ticks(input int n);
    repeat (n) @(posedge clk);
  endtask : ticks

  // Eight-cycle bit: data set two cycles before the clock rises
  task automatic bit_io(input logic b, output logic r);
    scl <= 1'b0;
    ticks(3);
    host_oe <= !b;
    ticks(2);
    scl <= 1'b1;
    ticks(2);
    r = sda;
    ticks(1);
  endtask : bit_io

  // Start is (0,1), stop is (1,0): data moves while the clock is high
  task automatic frame(input logic first, input logic second);
    scl <= 1'b0;
    ticks(6);
    host_oe <= first;
    ticks(2);
    scl <= 1'b1;
    ticks(4);
    host_oe <= second;
    ticks(4);
  endtask : frame

  task automatic byte_io(input logic [7:0] w, input logic ack_in, output logic [7:0] r,
                         output logic ack_out);
    logic b;
    for (int i = 7; i >= 0; i--)
    begin
      bit_io(w[i], b);
      r[i] = b;
    end
    bit_io(ack_in, ack_out);
  endtask : byte_io

  // Command plus nw data bytes, then nr bytes read after a repeated start
  task automatic transfer(input logic [6:0] addr, input logic [7:0] cmd, input int nw,
                          input logic [15:0] wdata, input int nr, output logic [15:0] rdata,
                          output logic ok);
    logic [7:0] rb;
    logic       a;
    ok = 1'b1;
    rdata = 16'h0000;
    frame(1'b0, 1'b1);
    byte_io({addr, 1'b0}, 1'b1, rb, a);
    ok &= !a;
    byte_io(cmd, 1'b1, rb, a);
    ok &= !a;
    for (int i = nw; i > 0; i--)
    begin
      byte_io(wdata[8*i-1 -: 8], 1'b1, rb, a);
      ok &= !a;
    end
    if (nr > 0)
    begin
      frame(1'b0, 1'b1);
      byte_io({addr, 1'b1}, 1'b1, rb, a);
      ok &= !a;
      for (int i = nr; i > 0; i--)
      begin
        byte_io(8'hff, i == 1, rb, a);
        rdata = {rdata[7:0], rb};
      end
    end
    frame(1'b1, 1'b0);
  endtask : transfer
endmodule : tcc_host_model

// [sim/temp_conversion_control_tb.sv]
`timescale 1ns/1ps
module temp_conversion_control_tb;
  localparam logic [25:0] CONV9 = 26'h28;
  localparam logic [18:0] NVW   = 19'h190;
  logic        clk_sys;
  logic        rst_b;
  logic        scl;
  logic        sda;
  logic        sda_oe;
  logic        sda_out;
  logic        auto_oe;
  logic        sensor_active;
  logic        conv_done;
  logic        nv_write_busy;
  logic        auto_done;
  logic [2:0]  sel;
  logic [6:0]  addr;
  logic [11:0] temp_sample;
  logic [15:0] rd;
  logic        ok;
  logic [15:0] defaults [4] = '{16'hc400, 16'h0f00, 16'h0a00, 16'h008c};
  int          errors = 0;
  int          samples_checked = 0;
  int          cycles = 0;
  int          done_count = 0;
  int          auto_count = 0;
  int          run_len = 0;
  int          last_len = 0;
  int          nv_len = 0;
  int          last_nv = 0;

  tcc_top #(.AUTO_START(1'b0), .CONV9_CYCLES(CONV9), .NV_WRITE_CYCLES(NVW)) tcc_top_i (
    .CLK_SYS(clk_sys), .RST_B(rst_b), .SCL(scl), .SDA_IN(sda), .SDA_OUT(sda_out),
    .SDA_OE(sda_oe),
    .BUS_ADDR_SEL0(sel[0]), .BUS_ADDR_SEL1(sel[1]), .BUS_ADDR_SEL2(sel[2]),
    .TEMP_SAMPLE(temp_sample), .SENSOR_ACTIVE(sensor_active), .CONV_DONE(conv_done),
    .NV_WRITE_BUSY(nv_write_busy));

  // Stand-alone unit on another address: hears all traffic, must stay silent
  tcc_top #(.AUTO_START(1'b1), .CONV9_CYCLES(CONV9), .NV_WRITE_CYCLES(NVW)) tcc_top_auto_i (
    .CLK_SYS(clk_sys), .RST_B(rst_b), .SCL(scl), .SDA_IN(sda), .SDA_OUT(), .SDA_OE(auto_oe),
    .BUS_ADDR_SEL0(~sel[0]), .BUS_ADDR_SEL1(~sel[1]), .BUS_ADDR_SEL2(~sel[2]),
    .TEMP_SAMPLE(temp_sample), .SENSOR_ACTIVE(), .CONV_DONE(auto_done), .NV_WRITE_BUSY());

  tcc_host_model tcc_host_model_i (.clk(clk_sys), .dev_oe(sda_oe | auto_oe), .scl(scl),
                                   .sda(sda));

  initial
  begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end

  task automatic stop_test;
    $display("Checks %0d, errors %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : stop_test

  task automatic chk_reg(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      errors++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk_reg

  task automatic chk_num(input int got, input int exp);
    chk_reg(16'(got), 16'(exp));
  endtask : chk_num

  task automatic bus(input logic [7:0] cmd, input int nw, input logic [15:0] wdata,
                     input int nr);
    tcc_host_model_i.transfer(addr, cmd, nw, wdata, nr, rd, ok);
    chk_reg({14'h0000, ok, sda_out}, 16'h0002);
  endtask : bus

  // Waits out any write cycle and any running conversion
  task automatic settle;
    for (int k = 0; k < 3000 && (nv_write_busy !== 1'b0 || sensor_active !== 1'b0); k++)
      @(posedge clk_sys);
    repeat (3) @(posedge clk_sys);
  endtask : settle

  always @(posedge clk_sys)
  begin
    cycles <= cycles + 1;
    done_count <= done_count + int'(conv_done === 1'b1);
    auto_count <= auto_count + int'(auto_done === 1'b1);
    run_len <= (sensor_active === 1'b1) ? run_len + 1 : 0;
    nv_len <= (nv_write_busy === 1'b1) ? nv_len + 1 : 0;
    if (sensor_active !== 1'b1 && run_len != 0)
      last_len <= run_len;
    if (nv_write_busy !== 1'b1 && nv_len != 0)
      last_nv <= nv_len;
    if (cycles == 60000)
    begin
      errors++;
      stop_test();
    end
  end

  initial
  begin
    logic [15:0] v;
    logic [11:0] s;
    int          d0;
    v = 16'($urandom(45));
    rst_b = 1'b0;
    sel = 3'($urandom);
    temp_sample = 12'($urandom);
    addr = {4'h9, sel};
    repeat (4) @(posedge clk_sys);
    rst_b <= 1'b1;
    repeat (40) @(posedge clk_sys);
    chk_reg({15'h0000, sensor_active}, 16'h0000);
    chk_num(done_count, 0);
    for (int i = 0; i < 4; i++)
    begin
      bus(8'h10 + 8'(i), 0, 16'h0000, (i == 3) ? 1 : 2);
      chk_reg(rd, defaults[i]);
    end
    bus(8'h10, 2, 16'h1234, 0);
    bus(8'h10, 0, 16'h0000, 2);
    chk_reg(rd, 16'hc400);
    for (int i = 1; i < 3; i++)
    begin
      v = {1'b1, 11'($urandom), 4'h0};
      bus(8'h10 + 8'(i), 2, v, 0);
      bus(8'h10 + 8'(i), 2, ~v, 0);
      settle();
      chk_num(last_nv, int'(NVW));
      bus(8'h10 + 8'(i), 0, 16'h0000, 2);
      chk_reg(rd, v);
    end
    for (int r = 0; r < 4; r++)
    begin
      v = {8'h00, 4'h0, 2'(r), 1'($urandom), 1'b1};
      bus(8'h13, 1, v, 0);
      settle();
      bus(8'h13, 0, 16'h0000, 2);
      chk_reg(rd, {8'(v | 16'h0080), 8'hff});
      s = 12'($urandom);
      temp_sample <= s;
      d0 = done_count;
      bus(8'h01, 0, 16'h0000, 0);
      if (r == 3)
        bus(8'h01, 0, 16'h0000, 0);
      settle();
      chk_num(last_len, int'(CONV9 << r));
      temp_sample <= ~s;
      bus(8'h10, 0, 16'h0000, 2);
      chk_reg(rd, {s, 4'h0} & (16'hffff << (7 - r)));
      repeat (400) @(posedge clk_sys);
      chk_num(done_count - d0, 1);
    end
    bus(8'h13, 1, 16'h0000, 0);
    settle();
    for (int k = 0; k < 2; k++)
    begin
      d0 = done_count;
      bus(8'h01, 0, 16'h0000, 0);
      repeat (300) @(posedge clk_sys);
      chk_num(int'(done_count - d0 >= 5), 1);
      bus(8'h02, 0, 16'h0000, 0);
      settle();
      d0 = done_count;
      repeat (300) @(posedge clk_sys);
      chk_num(done_count - d0, 0);
    end
    chk_num(int'(auto_count >= 20), 1);
    stop_test();
  end
endmodule : temp_conversion_control_tb
